// *** design/ckf_burst_if.sv ***
// Interface between the control top and the burst-amplitude killer
`timescale 1ns/1ps
`default_nettype none
interface ckf_burst_if #(
   parameter int AMP_W = 8
);
   logic enable;
   logic line_stb;
   logic [AMP_W-1:0] amp;
   logic [4:0] thr;
   logic [2:0] hyst;
   logic killed;

   modport ctrl (
      output enable,
      output line_stb,
      output amp,
      output thr,
      output hyst,
      input killed
   );

   modport kill (
      input enable,
      input line_stb,
      input amp,
      input thr,
      input hyst,
      output killed
   );
endinterface
`default_nettype wire

// *** design/ckf_burst_kill.sv ***
// Burst-amplitude chroma killer with hysteresis, evaluated once per line
`timescale 1ns/1ps
`default_nettype none
module ckf_burst_kill #(
   parameter int AMP_W = 8
) (
   input wire logic clk,
   input wire logic rst,
   ckf_burst_if.kill bif
);
   logic [5:0] restore_lvl;
   logic [AMP_W-1:0] thr_ext;
   logic [AMP_W-1:0] restore_ext;
   logic killed_reg;

   // Sum kept at 6 bits so threshold plus hysteresis never wraps
   assign restore_lvl = {1'b0, bif.thr} + {3'h0, bif.hyst};
   assign thr_ext = {{(AMP_W-5){1'b0}}, bif.thr};
   assign restore_ext = {{(AMP_W-6){1'b0}}, restore_lvl};

   always_ff @(posedge clk) begin
      if (rst) begin
         killed_reg <= 1'b0;
      end else if (!bif.enable) begin
         killed_reg <= 1'b0;
      end else if (bif.line_stb) begin // see RULE17
         if (!killed_reg && bif.amp < thr_ext) begin
            killed_reg <= 1'b1; // see RULE6
         end else if (killed_reg && bif.amp > restore_ext) begin
            killed_reg <= 1'b0; // see RULE7
         end
      end
   end

   assign bif.killed = killed_reg;
endmodule
`default_nettype wire

// *** design/ckf_ctrl_top.sv ***
// Top of the chroma kill, flesh tone and sync slice control register group
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// What this block does
// RULE1 - Option cleared: one good trial identifies
// RULE2 - Option set: every trial must succeed
// RULE3 - Two-bit mode selects kill behaviour
// RULE4 - Automatic mode kills chroma until identified
// RULE5 - Burst kill only in mode 11
// RULE6 - Kill when burst below threshold
// RULE7 - Restore above threshold plus hysteresis
// RULE8 - Phase bit picks 117 or 123 degrees
// RULE9 - Enable bit turns flesh correction on
// RULE10 - Slice fraction from blanking toward sync tip
// RULE11 - Slicing blanking equals clamp reference
// RULE12 - Sync tip comes from sync logic
// RULE13 - Host writes 1 into reserved bit 2
// RULE14 - Host writes zero to spare register
// RULE15 - Host writes 01 0000 to flesh low bits
// RULE16 - Host writes 0000 to slice low bits
// RULE17 - Burst comparison once per line, held
// ------------------------------------------------------------
module ckf_ctrl_top
   import ckf_pkg::*;
#(
   parameter int AMP_W = 8,
   parameter int LVL_W = 10
) (
   input wire logic CORE_CLK,
   input wire logic SYS_RST,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA,
   input wire logic TRIAL_VALID,
   input wire logic [2:0] TRIAL_STD,
   input wire logic TRIAL_OK,
   input wire logic SCAN_DONE,
   output logic [NUM_STD-1:0] STD_IDENT_MASK,
   output logic STD_IDENT,
   input wire logic LINE_STB,
   input wire logic [AMP_W-1:0] BURST_AMP,
   input wire logic [7:0] CHROMA_IN,
   output logic [7:0] CHROMA_OUT,
   output logic CHROMA_KILL,
   output logic FLESH_EN,
   output logic [7:0] FLESH_REF_ANGLE,
   input wire logic [LVL_W-1:0] CLAMP_BLANK_LVL,
   input wire logic [LVL_W-1:0] SYNC_TIP_LVL,
   output logic [LVL_W-1:0] HSYNC_SLICE_LVL
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic [7:0] ident_kill_reg;
   logic [7:0] spare_e_reg;
   logic [7:0] kill_level_reg;
   logic [7:0] flesh_reg;
   logic [7:0] slice_reg;
   logic [7:0] rdata_reg;

   logic [NUM_STD-1:0] seen_reg;
   logic [NUM_STD-1:0] any_ok_reg;
   logic [NUM_STD-1:0] all_ok_reg;
   logic [NUM_STD-1:0] ident_mask_reg;
   logic [NUM_STD-1:0] seen_next;
   logic [NUM_STD-1:0] any_ok_next;
   logic [NUM_STD-1:0] all_ok_next;
   logic [NUM_STD-1:0] trial_hot;

   logic require_all_trials;
   ckf_kill_mode_e kill_mode;
   logic identified;
   logic kill_next;
   logic kill_reg;
   logic [7:0] chroma_reg;
   logic flesh_en_reg;
   logic [7:0] angle_reg;
   logic [7:0] status_byte;

   ckf_burst_if #(.AMP_W(AMP_W)) burst_bus ();

   // ------------------------------------------------------------
   // Decoding helpers
   // ------------------------------------------------------------
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
      hit = (addr == off);
   endfunction

   function automatic logic [NUM_STD-1:0] one_hot(input logic [2:0] idx);
      one_hot = '0;
      one_hot[idx] = 1'b1;
   endfunction

   assign require_all_trials = ident_kill_reg[BIT_REQUIRE_ALL];
   assign kill_mode = ckf_kill_mode_e'(ident_kill_reg[KILL_MODE_LSB +: 2]);

   // ------------------------------------------------------------
   // Register writes
   // ------------------------------------------------------------
   // Reserved bits are stored as written; the host keeps them at
   // their required values, nothing here forces them.
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         ident_kill_reg <= RST_IDENT_KILL;
      end else if (REG_WR && hit(REG_ADDR, OFF_IDENT_KILL)) begin
         ident_kill_reg <= REG_WDATA; // see RULE13
      end
   end

   // Spare byte kept writable so the host's zero write reads back
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         spare_e_reg <= RST_SPARE_E;
      end else if (REG_WR && hit(REG_ADDR, OFF_SPARE_E)) begin
         spare_e_reg <= REG_WDATA; // see RULE14
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         kill_level_reg <= RST_KILL_LEVEL;
      end else if (REG_WR && hit(REG_ADDR, OFF_KILL_LEVEL)) begin
         kill_level_reg <= REG_WDATA;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         flesh_reg <= RST_FLESH;
      end else if (REG_WR && hit(REG_ADDR, OFF_FLESH)) begin
         flesh_reg <= REG_WDATA; // see RULE15
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         slice_reg <= RST_SLICE;
      end else if (REG_WR && hit(REG_ADDR, OFF_SLICE)) begin
         slice_reg <= REG_WDATA; // see RULE16
      end
   end

   // ------------------------------------------------------------
   // Register reads
   // ------------------------------------------------------------
   // Data stand only in the cycle after the strobe; zero otherwise.
   // Status and mask are read-only; writes to them are dropped.
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         rdata_reg <= 8'h00;
      end else if (REG_RD) begin
         unique case (REG_ADDR)
            OFF_IDENT_KILL: rdata_reg <= ident_kill_reg;
            OFF_SPARE_E: rdata_reg <= spare_e_reg;
            OFF_KILL_LEVEL: rdata_reg <= kill_level_reg;
            OFF_FLESH: rdata_reg <= flesh_reg;
            OFF_SLICE: rdata_reg <= slice_reg;
            OFF_STATUS: rdata_reg <= status_byte;
            OFF_IDENT_MASK: rdata_reg <= ident_mask_reg;
            default: rdata_reg <= 8'h00;
         endcase
      end else begin
         rdata_reg <= 8'h00;
      end
   end

   assign REG_RDATA = rdata_reg;

   // ------------------------------------------------------------
   // Status byte
   // ------------------------------------------------------------
   // Live view, captured only when a read strobe selects it
   always_comb begin
      status_byte = 8'h00;
      status_byte[ST_IDENT] = identified;
      status_byte[ST_BURST_KILLED] = burst_bus.killed;
      status_byte[ST_CHROMA_KILL] = kill_reg;
   end

   // ------------------------------------------------------------
   // Standard identification decision
   // ------------------------------------------------------------
   // A trial arriving with the scan end is counted in that scan.
   // The verdict waits for the scan end even with the option
   // cleared, as the whole table is tried before any decision.
   assign trial_hot = TRIAL_VALID ? one_hot(TRIAL_STD) : '0;
   assign seen_next = seen_reg | trial_hot;
   assign any_ok_next = TRIAL_OK ? (any_ok_reg | trial_hot) : any_ok_reg;
   assign all_ok_next = TRIAL_OK ? all_ok_reg : (all_ok_reg & ~trial_hot);

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST || SCAN_DONE) begin
         seen_reg <= '0;
         any_ok_reg <= '0;
         all_ok_reg <= '1;
      end else begin
         seen_reg <= seen_next;
         any_ok_reg <= any_ok_next;
         all_ok_reg <= all_ok_next;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         ident_mask_reg <= '0;
      end else if (SCAN_DONE) begin
         if (require_all_trials) begin
            ident_mask_reg <= seen_next & all_ok_next; // see RULE2
         end else begin
            ident_mask_reg <= any_ok_next; // see RULE1
         end
      end
   end

   // Any identified standard lifts the automatic kill
   assign identified = |ident_mask_reg;
   assign STD_IDENT_MASK = ident_mask_reg;
   assign STD_IDENT = identified;

   // ------------------------------------------------------------
   // Colour kill
   // ------------------------------------------------------------
   // Leaving mode 11 clears the burst state, so re-entry starts clean
   assign burst_bus.enable = (kill_mode == CKF_KILL_AUTO_BURST); // see RULE5
   assign burst_bus.line_stb = LINE_STB;
   assign burst_bus.amp = BURST_AMP;
   // Threshold and hysteresis cross unregistered; the killer only
   // looks at them on a line strobe
   assign burst_bus.thr = kill_level_reg[THR_LSB +: 5];
   assign burst_bus.hyst = kill_level_reg[HYST_LSB +: 3];

   ckf_burst_kill #(.AMP_W(AMP_W)) u_burst (
      .clk(CORE_CLK),
      .rst(SYS_RST),
      .bif(burst_bus)
   );

   always_comb begin
      unique case (kill_mode) // see RULE3
         CKF_KILL_AUTO: kill_next = !identified; // see RULE4
         CKF_KILL_NEVER: kill_next = 1'b0;
         CKF_KILL_ALWAYS: kill_next = 1'b1;
         CKF_KILL_AUTO_BURST: kill_next = !identified || burst_bus.killed;
      endcase
   end

   // Kill held in reset so no colour leaks before the first scan
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         kill_reg <= 1'b1;
      end else begin
         kill_reg <= kill_next;
      end
   end

   // Neutral code replaces chroma so downstream sees no colour
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         chroma_reg <= CHROMA_NEUTRAL;
      end else begin
         chroma_reg <= kill_next ? CHROMA_NEUTRAL : CHROMA_IN; // see RULE4
      end
   end

   assign CHROMA_KILL = kill_reg;
   assign CHROMA_OUT = chroma_reg;

   // ------------------------------------------------------------
   // Flesh tone
   // ------------------------------------------------------------
   // Registered together so enable and angle change on one edge
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         flesh_en_reg <= 1'b0;
         angle_reg <= FLESH_ANGLE_LO;
      end else begin
         flesh_en_reg <= flesh_reg[BIT_FLESH_EN]; // see RULE9
         angle_reg <= flesh_reg[BIT_FLESH_PH] ? FLESH_ANGLE_HI : FLESH_ANGLE_LO; // see RULE8
      end
   end

   assign FLESH_EN = flesh_en_reg;
   assign FLESH_REF_ANGLE = angle_reg;

   // ------------------------------------------------------------
   // Sync slicing
   // ------------------------------------------------------------
   // Blanking is the clamp reference itself, tip comes from sync logic
   ckf_slicer #(.LVL_W(LVL_W)) u_slicer (
      .clk(CORE_CLK),
      .rst(SYS_RST),
      .blank_lvl(CLAMP_BLANK_LVL), // see RULE11
      .tip_lvl(SYNC_TIP_LVL), // see RULE12
      .fraction(slice_reg[SLICE_LSB +: 4]),
      .slice_lvl(HSYNC_SLICE_LVL)
   );

endmodule
`default_nettype wire

// *** design/ckf_pkg.sv ***
// Constants, register map and types for the chroma kill / flesh / slice control group
package ckf_pkg;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFF_IDENT_KILL = 8'h0d;
   localparam logic [7:0] OFF_SPARE_E = 8'h0e;
   localparam logic [7:0] OFF_KILL_LEVEL = 8'h0f;
   localparam logic [7:0] OFF_FLESH = 8'h10;
   localparam logic [7:0] OFF_SLICE = 8'h11;
   localparam logic [7:0] OFF_STATUS = 8'h20;
   localparam logic [7:0] OFF_IDENT_MASK = 8'h21;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0] RST_IDENT_KILL = 8'h34;
   localparam logic [7:0] RST_SPARE_E = 8'h26;
   localparam logic [7:0] RST_KILL_LEVEL = 8'h00;
   localparam logic [7:0] RST_FLESH = 8'h10;
   localparam logic [7:0] RST_SLICE = 8'h88;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int BIT_REQUIRE_ALL = 3;
   localparam int KILL_MODE_LSB = 0;
   localparam int THR_LSB = 0;
   localparam int HYST_LSB = 5;
   localparam int BIT_FLESH_PH = 7;
   localparam int BIT_FLESH_EN = 6;
   localparam int SLICE_LSB = 4;
   localparam int ST_IDENT = 0;
   localparam int ST_BURST_KILLED = 1;
   localparam int ST_CHROMA_KILL = 2;

   // ------------------------------------------------------------
   // Values
   // ------------------------------------------------------------
   localparam int NUM_STD = 8;
   localparam logic [7:0] FLESH_ANGLE_LO = 8'd117;
   localparam logic [7:0] FLESH_ANGLE_HI = 8'd123;
   localparam logic [7:0] CHROMA_NEUTRAL = 8'h80;

   typedef enum logic [1:0] {
      CKF_KILL_AUTO = 2'b00,
      CKF_KILL_NEVER = 2'b01,
      CKF_KILL_ALWAYS = 2'b10,
      CKF_KILL_AUTO_BURST = 2'b11
   } ckf_kill_mode_e;

endpackage

// *** design/ckf_slicer.sv ***
// Horizontal-PLL slice level between blanking and sync tip
`timescale 1ns/1ps
`default_nettype none
module ckf_slicer #(
   parameter int LVL_W = 10
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [LVL_W-1:0] blank_lvl,
   input wire logic [LVL_W-1:0] tip_lvl,
   input wire logic [3:0] fraction,
   output logic [LVL_W-1:0] slice_lvl
);
   logic [LVL_W-1:0] span;
   logic [LVL_W+3:0] prod;
   logic [LVL_W-1:0] step;
   logic [LVL_W-1:0] slice_reg;

   // Inverted levels give a zero span rather than a wrapped one
   assign span = (blank_lvl >= tip_lvl) ? blank_lvl - tip_lvl : '0;
   assign prod = span * fraction;
   assign step = prod[LVL_W+3:4];

   always_ff @(posedge clk) begin
      if (rst) begin
         slice_reg <= '0;
      end else begin
         slice_reg <= blank_lvl - step; // see RULE10
      end
   end

   assign slice_lvl = slice_reg;
endmodule
`default_nettype wire

// *** verif/ckf_ctrl_monitor.sv ***
// Port checker for the control register group
`timescale 1ns/1ps
`default_nettype none
module ckf_ctrl_monitor
   import ckf_pkg::*;
#(
   parameter int AMP_W = 8,
   parameter int LVL_W = 10
) (
   input wire logic CORE_CLK,
   input wire logic SYS_RST,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [7:0] REG_RDATA,
   input wire logic SCAN_DONE,
   input wire logic [NUM_STD-1:0] STD_IDENT_MASK,
   input wire logic STD_IDENT,
   input wire logic LINE_STB,
   input wire logic [AMP_W-1:0] BURST_AMP,
   input wire logic [7:0] CHROMA_IN,
   input wire logic [7:0] CHROMA_OUT,
   input wire logic CHROMA_KILL,
   input wire logic FLESH_EN,
   input wire logic [7:0] FLESH_REF_ANGLE
);
   // ----
   // Register shadows
   // ----
   logic [1:0] mode_reg;
   logic [7:0] lvl_reg;
   logic [7:0] fl_reg;
   logic [AMP_W-1:0] thr;
   assign thr = AMP_W'(lvl_reg[4:0]);
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         mode_reg <= 2'b00;
         lvl_reg <= RST_KILL_LEVEL;
         fl_reg <= RST_FLESH;
      end else if (REG_WR) begin
         if (REG_ADDR == OFF_IDENT_KILL) mode_reg <= REG_WDATA[1:0];
         if (REG_ADDR == OFF_KILL_LEVEL) lvl_reg <= REG_WDATA;
         if (REG_ADDR == OFF_FLESH) fl_reg <= REG_WDATA;
      end
   end
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (SYS_RST);
   a_read_quiet: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
      else $error("read data outside its cycle");
   a_level_read: assert property ((REG_RD && REG_ADDR == OFF_KILL_LEVEL) |=> REG_RDATA == $past(lvl_reg))
      else $error("kill level read back wrong");
   a_kill_never: assert property ($past(mode_reg) == 2'b01 |-> !CHROMA_KILL)
      else $error("chroma killed in never mode");
   a_kill_always: assert property ($past(mode_reg) == 2'b10 |-> CHROMA_KILL)
      else $error("chroma kept in always mode");
   a_auto_follow: assert property ((!$past(SYS_RST) && $past(mode_reg) == 2'b00) |-> CHROMA_KILL == !$past(STD_IDENT))
      else $error("auto kill not tied to ident");
   a_kill_output: assert property (!$past(SYS_RST) |-> CHROMA_OUT == (CHROMA_KILL ? 8'h80 : $past(CHROMA_IN)))
      else $error("chroma output wrong");
   a_ident_hold: assert property ((!$past(SYS_RST) && !$past(SCAN_DONE)) |-> $stable(STD_IDENT_MASK))
      else $error("ident mask moved without scan end");
   a_ident_any: assert property (STD_IDENT == |STD_IDENT_MASK)
      else $error("ident flag not mask or");
   a_burst_low: assert property ((mode_reg == 2'b11 && LINE_STB && BURST_AMP < thr && !REG_WR) ##1 !REG_WR |=> CHROMA_KILL)
      else $error("low burst did not kill");
   a_flesh_out: assert property (!$past(SYS_RST) |-> FLESH_EN == $past(fl_reg[6]) && FLESH_REF_ANGLE == ($past(fl_reg[7]) ? 8'd123 : 8'd117))
      else $error("flesh outputs wrong");
endmodule
bind ckf_ctrl_top ckf_ctrl_monitor #(.AMP_W(AMP_W), .LVL_W(LVL_W)) i_mon (.*);
`default_nettype wire

// *** verif/ckf_ctrl_top_test.sv ***
// Self-checking bench of the control register group
`timescale 1ns/1ps
`default_nettype none
module ckf_ctrl_top_test;
   import ckf_pkg::*;
   logic CORE_CLK = 1'b0;
   logic SYS_RST = 1'b1;
   wire logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
   wire logic REG_WR, REG_RD;
   logic TRIAL_VALID = 1'b0, TRIAL_OK = 1'b0, SCAN_DONE = 1'b0, LINE_STB = 1'b0;
   logic [2:0] TRIAL_STD = 3'h0;
   logic [7:0] BURST_AMP = 8'h00, CHROMA_IN = 8'h00;
   logic [9:0] CLAMP_BLANK_LVL = 10'h000, SYNC_TIP_LVL = 10'h000;
   wire logic [7:0] STD_IDENT_MASK, CHROMA_OUT, FLESH_REF_ANGLE;
   wire logic STD_IDENT, CHROMA_KILL, FLESH_EN;
   wire logic [9:0] HSYNC_SLICE_LVL;
   int mismatches = 0;
   int n_checks = 0;
   int seed = 15086;
   int cyc = 0;
   logic [7:0] d, a;
   logic [9:0] b, t;
   logic [3:0] f;
   logic kd;
   logic [7:0] ra[6] = '{8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h30};
   logic [7:0] rv[6] = '{8'h34, 8'h26, 8'h00, 8'h10, 8'h88, 8'h00};
   always #2 CORE_CLK = ~CORE_CLK;
   always @(posedge CORE_CLK) CHROMA_IN <= 8'($random(seed));
   ckf_ctrl_top i_dut (.*);
   ckf_host_model i_host (.*);
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   always @(posedge CORE_CLK) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         $display("ERROR t=%0t timeout", $time);
         mismatches++;
         finish_test();
      end
   end
   task automatic chk(input logic [9:0] g, input logic [9:0] e);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // Burst state after one line: kill below threshold, restore above it plus hysteresis
   function automatic logic burst_next(input logic k, input logic [7:0] a);
      burst_next = k ? !(a > 8'd12) : (a < 8'd10);
   endfunction
   // ----
   // Identification scan, first two trials are a fixed corner
   // ----
   task automatic scan(input logic all, input int n);
      logic [7:0] ok, bad;
      logic [2:0] s;
      logic o;
      logic [7:0] e;
      ok = 8'h00;
      bad = 8'h00;
      i_host.wr(OFF_IDENT_KILL, {4'h3, all, 3'b100});
      for (int k = 0; k < n; k++) begin
         s = (k < 2) ? 3'd2 : 3'($random(seed));
         o = (k < 2) ? (k == 0) : 1'($random(seed));
         ok[s] = ok[s] | o;
         bad[s] = bad[s] | !o;
         @(posedge CORE_CLK);
         TRIAL_VALID <= 1'b1;
         TRIAL_STD <= s;
         TRIAL_OK <= o;
      end
      @(posedge CORE_CLK);
      TRIAL_VALID <= 1'b0;
      SCAN_DONE <= 1'b1;
      @(posedge CORE_CLK);
      SCAN_DONE <= 1'b0;
      @(posedge CORE_CLK);
      e = all ? (ok & ~bad) : ok;
      #1 chk(STD_IDENT_MASK, e);
      chk(STD_IDENT, |e);
      i_host.rd(OFF_IDENT_MASK, d);
      chk(d, e);
   endtask
   task automatic kmode(input logic [1:0] m, input logic e);
      i_host.wr(OFF_IDENT_KILL, {6'h0d, m});
      repeat (2) @(posedge CORE_CLK);
      #1 chk(CHROMA_KILL, e);
   endtask
   task automatic line(input logic [7:0] a, input logic e);
      @(posedge CORE_CLK);
      LINE_STB <= 1'b1;
      BURST_AMP <= a;
      @(posedge CORE_CLK);
      LINE_STB <= 1'b0;
      BURST_AMP <= ~a;
      @(posedge CORE_CLK);
      #1 chk(CHROMA_KILL, e);
   endtask
   initial begin
      repeat (6) @(posedge CORE_CLK);
      SYS_RST <= 1'b0;
      foreach (ra[k]) begin
         i_host.rd(ra[k], d);
         chk(d, rv[k]);
      end
      i_host.wr(OFF_SPARE_E, 8'h5a);
      i_host.rd(OFF_SPARE_E, d);
      chk(d, 8'h00);
      scan(1'b1, 12);
      scan(1'b0, 0);
      i_host.rd(OFF_STATUS, d);
      chk(d, 8'h04);
      for (int m = 0; m < 4; m++) kmode(2'(m), m != 1);
      scan(1'b0, 12);
      for (int m = 0; m < 4; m++) kmode(2'(m), m == 2);
      i_host.wr(OFF_KILL_LEVEL, 8'h4a);
      i_host.rd(OFF_KILL_LEVEL, d);
      chk(d, 8'h4a);
      line(8'd10, 1'b0);
      line(8'd9, 1'b1);
      i_host.rd(OFF_STATUS, d);
      chk(d, 8'h07);
      line(8'd12, 1'b1);
      line(8'd13, 1'b0);
      kd = 1'b0;
      repeat (12) begin
         a = 8'($random(seed)) & 8'h1f;
         kd = burst_next(kd, a);
         line(a, kd);
      end
      kmode(2'b00, 1'b0);
      line(8'd0, 1'b0);
      for (int k = 0; k < 4; k++) begin
         i_host.wr(OFF_FLESH, {2'(k), 6'h10});
         @(posedge CORE_CLK);
         #1 chk(FLESH_EN, k[0]);
         chk(FLESH_REF_ANGLE, k[1] ? 8'd123 : 8'd117);
      end
      for (int k = 0; k < 6; k++) begin
         f = (k == 0) ? 4'h0 : (k == 1) ? 4'hf : 4'($random(seed));
         t = 10'($random(seed)) >> 1;
         b = t + (10'($random(seed)) >> 1);
         @(posedge CORE_CLK);
         CLAMP_BLANK_LVL <= b;
         SYNC_TIP_LVL <= t;
         i_host.wr(OFF_SLICE, {f, 4'h0});
         @(posedge CORE_CLK);
         #1 chk(HSYNC_SLICE_LVL, b - 10'((14'(b - t) * 14'(f)) >> 4));
      end
      // Mid-run reset: defaults return, chroma killed until identified
      @(posedge CORE_CLK);
      SYS_RST <= 1'b1;
      repeat (2) @(posedge CORE_CLK);
      SYS_RST <= 1'b0;
      @(posedge CORE_CLK);
      #1 chk(CHROMA_KILL, 1'b1);
      chk(CHROMA_OUT, 8'h80);
      chk(STD_IDENT_MASK, 8'h00);
      chk(FLESH_EN, 1'b0);
      chk(FLESH_REF_ANGLE, FLESH_ANGLE_LO);
      chk(HSYNC_SLICE_LVL, b - 10'((14'(b - t) * 14'(RST_SLICE[7:4])) >> 4));
      i_host.rd(OFF_FLESH, d);
      chk(d, RST_FLESH);
      finish_test();
   end
endmodule
`default_nettype wire

// *** verif/ckf_host_model.sv ***
// Host model driving the register port of the control group
`timescale 1ns/1ps
`default_nettype none
module ckf_host_model (
   input wire logic CORE_CLK,
   input wire logic [7:0] REG_RDATA,
   output logic [7:0] REG_ADDR,
   output logic [7:0] REG_WDATA,
   output logic REG_WR,
   output logic REG_RD
);
   initial begin
      REG_ADDR = 8'h00;
      REG_WDATA = 8'h00;
      REG_WR = 1'b0;
      REG_RD = 1'b0;
   end
   // Reserved bits always carry their required pattern
   function automatic logic [7:0] fix(input logic [7:0] a, input logic [7:0] d);
      case (a)
         8'h0d: fix = d | 8'h04;
         8'h0e: fix = 8'h00;
         8'h10: fix = {d[7:6], 6'h10};
         8'h11: fix = {d[7:4], 4'h0};
         default: fix = d;
      endcase
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge CORE_CLK);
      REG_ADDR <= a;
      REG_WDATA <= fix(a, d);
      REG_WR <= 1'b1;
      @(posedge CORE_CLK);
      REG_WR <= 1'b0;
      // Released data must not look still valid
      REG_WDATA <= ~fix(a, d);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge CORE_CLK);
      REG_ADDR <= a;
      REG_RD <= 1'b1;
      @(posedge CORE_CLK);
      REG_RD <= 1'b0;
      #1 d = REG_RDATA;
   endtask
endmodule
`default_nettype wire
